// ===== rtl/rpc_pkg.sv
`default_nettype none
package rpc_pkg;

	// ==========================================================
	// bus and register map
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 24;
	localparam int STRB_W = 4;
	localparam logic [ADDR_W-1:0] RESP_CTRL_IDX = 8'h03;
	localparam logic [ADDR_W-1:0] PACE_CTRL_IDX = 8'h04;
	localparam logic [ADDR_W-1:0] RESP_CTRL_ADDR = 8'h0C;
	localparam logic [ADDR_W-1:0] PACE_CTRL_ADDR = 8'h10;
	localparam logic [REG_W-1:0] RESP_CTRL_RESET = 24'h000000;
	localparam logic [REG_W-1:0] PACE_CTRL_RESET = 24'h000F88;

	// ==========================================================
	// respiration control fields and implemented bits
	localparam int RESP_ALT_FREQ_BIT = 16;
	localparam int RESP_EXT_SYNC_BIT = 15;
	localparam int RESP_EXT_PATH_BIT = 7;
	localparam int RESP_LEAD_LSB = 5;
	localparam int RESP_AMP_LSB = 3;
	localparam int RESP_FREQ_LSB = 1;
	localparam int RESP_EN_BIT = 0;
	localparam logic [REG_W-1:0] RESP_CTRL_MASK = 24'h0180FF;

	// ==========================================================
	// pace control fields
	localparam int PACE_WIDTH_FILT_BIT = 11;
	localparam int PACE_VALID_TWO_BIT = 10;
	localparam int PACE_VALID_ONE_BIT = 9;
	localparam int PACE_THREE_LEAD_LSB = 7;
	localparam int PACE_TWO_LEAD_LSB = 5;
	localparam int PACE_ONE_LEAD_LSB = 3;
	localparam int PACE_THREE_EN_BIT = 2;
	localparam int PACE_TWO_EN_BIT = 1;
	localparam int PACE_ONE_EN_BIT = 0;
	localparam logic [REG_W-1:0] PACE_CTRL_MASK = 24'h000FFF;

	// ==========================================================
	// field encodings
	typedef enum logic [1:0] {
		RPC_LEAD_I = 2'h0,
		RPC_LEAD_II = 2'h1,
		RPC_LEAD_III = 2'h2,
		RPC_LEAD_EXT = 2'h3
	} rpc_resp_lead_t;

	typedef enum logic [1:0] {
		RPC_AMP_EIGHTH = 2'h0,
		RPC_AMP_QUARTER = 2'h1,
		RPC_AMP_HALF = 2'h2,
		RPC_AMP_FULL = 2'h3
	} rpc_amp_t;

	// ==========================================================
	// carrier timing, standard frequencies in Hz, alternate frequencies in tenths of Hz
	localparam longint CLK_HZ = 100000000;
	localparam int ACC_W = 24;
	localparam longint F_STD0_HZ = 56000;
	localparam longint F_STD1_HZ = 54000;
	localparam longint F_STD2_HZ = 52000;
	localparam longint F_STD3_HZ = 50000;
	localparam longint F_ALT0_DHZ = 640000;
	localparam longint F_ALT1_DHZ = 569000;
	localparam longint F_ALT2_DHZ = 512000;
	localparam longint F_ALT3_DHZ = 465000;
	localparam int PER_W = 12;
	localparam int INC_W = 16;
	// phase step per clock for the jittery standard carrier
	localparam logic [INC_W-1:0] STD0_INC =
		INC_W'((F_STD0_HZ << ACC_W) / CLK_HZ);
	localparam logic [INC_W-1:0] STD1_INC =
		INC_W'((F_STD1_HZ << ACC_W) / CLK_HZ);
	localparam logic [INC_W-1:0] STD2_INC =
		INC_W'((F_STD2_HZ << ACC_W) / CLK_HZ);
	localparam logic [INC_W-1:0] STD3_INC =
		INC_W'((F_STD3_HZ << ACC_W) / CLK_HZ);
	// half period in cycles for the strictly periodic carrier
	localparam logic [PER_W-1:0] ALT0_HALF =
		PER_W'((CLK_HZ * 10) / (F_ALT0_DHZ * 2));
	localparam logic [PER_W-1:0] ALT1_HALF =
		PER_W'((CLK_HZ * 10) / (F_ALT1_DHZ * 2));
	localparam logic [PER_W-1:0] ALT2_HALF =
		PER_W'((CLK_HZ * 10) / (F_ALT2_DHZ * 2));
	localparam logic [PER_W-1:0] ALT3_HALF =
		PER_W'((CLK_HZ * 10) / (F_ALT3_DHZ * 2));

	// ==========================================================
	// bus slave states, gray along idle -> access
	typedef enum logic [1:0] {
		RPC_IDLE = 2'b00,
		RPC_ACCESS = 2'b01
	} rpc_state_t;

endpackage
`default_nettype wire

// ===== rtl/rpc_carrier_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rpc_carrier_if;
	logic enable;
	logic alt_freq;
	logic [1:0] freq_code;
	logic msb;

	modport ctrl (
		output enable,
		output alt_freq,
		output freq_code,
		input msb
	);

	modport gen (
		input enable,
		input alt_freq,
		input freq_code,
		output msb
	);
endinterface
`default_nettype wire

// ===== rtl/rpc_carrier_gen.sv
`timescale 1ns/10ps
`default_nettype none
module rpc_carrier_gen (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// control and carrier msb
	rpc_carrier_if.gen car
);

	// ==========================================================
	// step and period lookup
	function automatic logic [rpc_pkg::INC_W-1:0] std_inc(
		input logic [1:0] code);
		case (code)
			2'h0: std_inc = rpc_pkg::STD0_INC;
			2'h1: std_inc = rpc_pkg::STD1_INC;
			2'h2: std_inc = rpc_pkg::STD2_INC;
			default: std_inc = rpc_pkg::STD3_INC;
		endcase
	endfunction

	function automatic logic [rpc_pkg::PER_W-1:0] alt_half(
		input logic [1:0] code);
		case (code)
			2'h0: alt_half = rpc_pkg::ALT0_HALF;
			2'h1: alt_half = rpc_pkg::ALT1_HALF;
			2'h2: alt_half = rpc_pkg::ALT2_HALF;
			default: alt_half = rpc_pkg::ALT3_HALF;
		endcase
	endfunction

	logic [rpc_pkg::ACC_W-1:0] phase_acc;
	logic [rpc_pkg::PER_W-1:0] half_cnt;
	logic alt_level;

	// ==========================================================
	// standard mode: phase accumulator, edges land on whole cycles
	// so the period wanders by one cycle
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_acc <= '0;
		end else if (!car.enable || car.alt_freq) begin
			phase_acc <= '0;
		end else begin
			phase_acc <= phase_acc + rpc_pkg::ACC_W'(std_inc(car.freq_code));
		end
	end

	// ==========================================================
	// alternate mode: fixed half period divider, strictly periodic
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			half_cnt <= '0;
			alt_level <= 1'b0;
		end else if (!car.enable || !car.alt_freq) begin
			half_cnt <= '0;
			alt_level <= 1'b0;
		end else if (half_cnt >= alt_half(car.freq_code) - 1'b1) begin
			half_cnt <= '0;
			alt_level <= ~alt_level;
		end else begin
			half_cnt <= half_cnt + 1'b1;
		end
	end

	assign car.msb = car.alt_freq ? alt_level :
		phase_acc[rpc_pkg::ACC_W-1];

endmodule
`default_nettype wire

// ===== rtl/rpc_regs.sv
// Function
// R1: respiration register at index 0x03, all zeros after reset.
// R2: both registers exist only when the full variant parameter is set.
// R3: bit 7 picks external path pair, only meaningful with external lead.
// R4: bits 6:5 pick respiration lead I, II, III or external.
// R5: bits 4:3 scale drive amplitude one eighth up to full.
// R6: bits 2:1 set carrier 56/54/52/50 kHz when alternate clear.
// R7: with alternate set carrier is periodic 64/56.9/51.2/46.5 kHz.
// R8: bit 0 enables respiration, reset value zero.
// R9: pace filter enables at bits 11, 10, 9, each resetting to one.
// R10: three two-bit detector lead fields, resets 11, 00, 01.
// R11: bits 2..0 enable detectors three, two, one, reset zero.
// R12: pace register at index 0x04, reset value 0x000F88.
// R13: external sync drives carrier msb onto general pin three.
// R14: host writes zero to pace bits 23:12, ignores their read value.
// R15: fields hold written value until rewrite or reset; reads return it.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rpc_regs #(
	parameter bit FULL_VARIANT = 1'b1
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [rpc_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [rpc_pkg::DATA_W-1:0] pwdata_i,
	input wire logic [rpc_pkg::STRB_W-1:0] pstrb_i,
	output logic [rpc_pkg::DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// respiration controls
	output logic resp_enable_o,
	output logic ext_resp_path_select_o,
	output logic [1:0] resp_lead_select_o,
	output logic [1:0] resp_drive_amplitude_o,
	output logic [1:0] resp_carrier_freq_o,
	output logic resp_alternate_freq_o,
	output logic resp_external_sync_o,
	// pace controls
	output logic pace_width_filter_en_o,
	output logic pace_valid_filter_two_en_o,
	output logic pace_valid_filter_one_en_o,
	output logic [1:0] pace_det_one_lead_o,
	output logic [1:0] pace_det_two_lead_o,
	output logic [1:0] pace_det_three_lead_o,
	output logic pace_det_one_enable_o,
	output logic pace_det_two_enable_o,
	output logic pace_det_three_enable_o,
	// general pin three
	input wire logic general_pin_three_normal_i,
	output logic general_pin_three_o
);

	// ==========================================================
	// helpers
	typedef enum logic [1:0] {
		RPC_SEL_NONE = 2'h0,
		RPC_SEL_RESP = 2'h1,
		RPC_SEL_PACE = 2'h2
	} rpc_sel_t;

	// decode used by both read and write paths
	function automatic rpc_sel_t reg_decode(
		input logic [rpc_pkg::ADDR_W-1:0] addr);
		if (!FULL_VARIANT) begin
			reg_decode = RPC_SEL_NONE;
		end else if (addr == rpc_pkg::RESP_CTRL_ADDR) begin
			reg_decode = RPC_SEL_RESP;
		end else if (addr == rpc_pkg::PACE_CTRL_ADDR) begin
			reg_decode = RPC_SEL_PACE;
		end else begin
			reg_decode = RPC_SEL_NONE;
		end
	endfunction

	// byte-lane merge limited to implemented bits
	function automatic logic [rpc_pkg::REG_W-1:0] lane_merge(
		input logic [rpc_pkg::REG_W-1:0] old_val,
		input logic [rpc_pkg::DATA_W-1:0] wdata,
		input logic [rpc_pkg::STRB_W-1:0] strb,
		input logic [rpc_pkg::REG_W-1:0] mask);
		logic [rpc_pkg::REG_W-1:0] lanes;
		lanes = {{8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		lanes = lanes & mask;
		lane_merge = (old_val & ~lanes) |
			(wdata[rpc_pkg::REG_W-1:0] & lanes);
	endfunction

	rpc_pkg::rpc_state_t state;
	rpc_pkg::rpc_state_t next_state;
	rpc_sel_t setup_sel;
	logic setup_phase;
	logic write_fire;
	logic [rpc_pkg::REG_W-1:0] resp_ctrl;
	logic [rpc_pkg::REG_W-1:0] pace_ctrl;
	logic [rpc_pkg::REG_W-1:0] read_word;
	// pace outputs leave reset matching the register's reset word
	localparam logic [rpc_pkg::REG_W-1:0] PACE_RST = rpc_pkg::PACE_CTRL_RESET;

	rpc_carrier_if car ();

	assign setup_phase = psel_i && !penable_i;
	assign setup_sel = reg_decode(paddr_i);
	// write commits at the edge that samples the completing access
	assign write_fire = psel_i && penable_i && pready_o && pwrite_i &&
		!pslverr_o;

	// ==========================================================
	// bus state
	always_comb begin
		next_state = state;
		case (state)
			rpc_pkg::RPC_IDLE: begin
				if (setup_phase) begin
					next_state = rpc_pkg::RPC_ACCESS;
				end
			end
			rpc_pkg::RPC_ACCESS: begin
				if (setup_phase) begin
					next_state = rpc_pkg::RPC_ACCESS;
				end else begin
					next_state = rpc_pkg::RPC_IDLE;
				end
			end
			default: begin
				next_state = rpc_pkg::RPC_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= rpc_pkg::RPC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ready answers in the first access cycle, one cycle after setup
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_o <= 1'b0;
		end else begin
			pready_o <= setup_phase;
		end
	end

	// unmapped addresses, and every address on the reduced variant
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pslverr_o <= 1'b0;
		end else if (setup_phase) begin
			pslverr_o <= (setup_sel == RPC_SEL_NONE); // R2
		end else begin
			pslverr_o <= 1'b0;
		end
	end

	// ==========================================================
	// read path
	always_comb begin
		case (setup_sel)
			RPC_SEL_RESP: read_word = resp_ctrl & rpc_pkg::RESP_CTRL_MASK; // R15
			RPC_SEL_PACE: read_word = pace_ctrl & rpc_pkg::PACE_CTRL_MASK; // R15
			default: read_word = '0;
		endcase
	end

	// data is captured at setup so it is steady through the access
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o <= '0;
		end else if (setup_phase && !pwrite_i) begin
			prdata_o <= rpc_pkg::DATA_W'(read_word);
		end else if (setup_phase) begin
			prdata_o <= '0;
		end
	end

	// ==========================================================
	// respiration control register
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			resp_ctrl <= rpc_pkg::RESP_CTRL_RESET; // R1
		end else if (write_fire && reg_decode(paddr_i) == RPC_SEL_RESP) begin
			resp_ctrl <= lane_merge(resp_ctrl, pwdata_i, pstrb_i,
				rpc_pkg::RESP_CTRL_MASK); // R1 R15
		end
	end

	// ==========================================================
	// pace control register; bits 23:12 are not stored
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pace_ctrl <= rpc_pkg::PACE_CTRL_RESET; // R12 R9 R10 R11
		end else if (write_fire && reg_decode(paddr_i) == RPC_SEL_PACE) begin
			pace_ctrl <= lane_merge(pace_ctrl, pwdata_i, pstrb_i,
				rpc_pkg::PACE_CTRL_MASK); // R12 R14 R15
		end
	end

	// ==========================================================
	// respiration field outputs
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			resp_enable_o <= 1'b0;
			ext_resp_path_select_o <= 1'b0;
			resp_lead_select_o <= rpc_pkg::RPC_LEAD_I;
			resp_drive_amplitude_o <= rpc_pkg::RPC_AMP_EIGHTH;
			resp_carrier_freq_o <= '0;
			resp_alternate_freq_o <= 1'b0;
			resp_external_sync_o <= 1'b0;
		end else begin
			resp_enable_o <= resp_ctrl[rpc_pkg::RESP_EN_BIT]; // R8
			// path pair only matters once the external lead is chosen
			ext_resp_path_select_o <= resp_ctrl[rpc_pkg::RESP_EXT_PATH_BIT] &&
				(resp_ctrl[rpc_pkg::RESP_LEAD_LSB +: 2] ==
				rpc_pkg::RPC_LEAD_EXT); // R3
			resp_lead_select_o <= resp_ctrl[rpc_pkg::RESP_LEAD_LSB +: 2]; // R4
			resp_drive_amplitude_o <= resp_ctrl[rpc_pkg::RESP_AMP_LSB +: 2]; // R5
			resp_carrier_freq_o <= resp_ctrl[rpc_pkg::RESP_FREQ_LSB +: 2]; // R6
			resp_alternate_freq_o <=
				resp_ctrl[rpc_pkg::RESP_ALT_FREQ_BIT]; // R7
			resp_external_sync_o <= resp_ctrl[rpc_pkg::RESP_EXT_SYNC_BIT];
		end
	end

	// ==========================================================
	// pace field outputs
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pace_width_filter_en_o <=
				PACE_RST[rpc_pkg::PACE_WIDTH_FILT_BIT]; // R9
			pace_valid_filter_two_en_o <=
				PACE_RST[rpc_pkg::PACE_VALID_TWO_BIT]; // R9
			pace_valid_filter_one_en_o <=
				PACE_RST[rpc_pkg::PACE_VALID_ONE_BIT]; // R9
			pace_det_three_lead_o <=
				PACE_RST[rpc_pkg::PACE_THREE_LEAD_LSB +: 2]; // R10
			pace_det_two_lead_o <=
				PACE_RST[rpc_pkg::PACE_TWO_LEAD_LSB +: 2]; // R10
			pace_det_one_lead_o <=
				PACE_RST[rpc_pkg::PACE_ONE_LEAD_LSB +: 2]; // R10
			pace_det_three_enable_o <=
				PACE_RST[rpc_pkg::PACE_THREE_EN_BIT]; // R11
			pace_det_two_enable_o <=
				PACE_RST[rpc_pkg::PACE_TWO_EN_BIT]; // R11
			pace_det_one_enable_o <=
				PACE_RST[rpc_pkg::PACE_ONE_EN_BIT]; // R11
		end else begin
			pace_width_filter_en_o <=
				pace_ctrl[rpc_pkg::PACE_WIDTH_FILT_BIT]; // R9
			pace_valid_filter_two_en_o <=
				pace_ctrl[rpc_pkg::PACE_VALID_TWO_BIT]; // R9
			pace_valid_filter_one_en_o <=
				pace_ctrl[rpc_pkg::PACE_VALID_ONE_BIT]; // R9
			pace_det_three_lead_o <=
				pace_ctrl[rpc_pkg::PACE_THREE_LEAD_LSB +: 2]; // R10
			pace_det_two_lead_o <=
				pace_ctrl[rpc_pkg::PACE_TWO_LEAD_LSB +: 2]; // R10
			pace_det_one_lead_o <=
				pace_ctrl[rpc_pkg::PACE_ONE_LEAD_LSB +: 2]; // R10
			pace_det_three_enable_o <=
				pace_ctrl[rpc_pkg::PACE_THREE_EN_BIT]; // R11
			pace_det_two_enable_o <= pace_ctrl[rpc_pkg::PACE_TWO_EN_BIT]; // R11
			pace_det_one_enable_o <= pace_ctrl[rpc_pkg::PACE_ONE_EN_BIT]; // R11
		end
	end

	// ==========================================================
	// respiration drive generator
	assign car.enable = resp_ctrl[rpc_pkg::RESP_EN_BIT];
	assign car.alt_freq = resp_ctrl[rpc_pkg::RESP_ALT_FREQ_BIT]; // R7
	assign car.freq_code = resp_ctrl[rpc_pkg::RESP_FREQ_LSB +: 2]; // R6

	rpc_carrier_gen u_carrier (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.car(car.gen)
	);

	// ==========================================================
	// general pin three: normal function unless sync is asked for;
	// the msb is only evenly spaced in alternate mode
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			general_pin_three_o <= 1'b0;
		end else if (resp_ctrl[rpc_pkg::RESP_EXT_SYNC_BIT]) begin
			general_pin_three_o <= car.msb; // R13
		end else begin
			general_pin_three_o <= general_pin_three_normal_i;
		end
	end

endmodule
`default_nettype wire

// ===== dv/rpc_regs_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module rpc_regs_monitor (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [rpc_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [rpc_pkg::DATA_W-1:0] pwdata_i,
	input wire logic [rpc_pkg::STRB_W-1:0] pstrb_i,
	input wire logic [rpc_pkg::DATA_W-1:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// fields and pin
	input wire logic resp_enable_o,
	input wire logic ext_resp_path_select_o,
	input wire logic [1:0] resp_lead_select_o,
	input wire logic resp_external_sync_o,
	input wire logic pace_width_filter_en_o,
	input wire logic general_pin_three_normal_i,
	input wire logic general_pin_three_o
);
	// ==========================================
	// bus phases
	logic setup;
	logic commit;
	assign setup = psel_i && !penable_i;
	assign commit = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// ==========================================
	// checks
	a_ready_after_setup: assert property (setup |=> pready_o)
		else $error("no ready after setup");
	a_ready_single: assert property (pready_o |=> !pready_o)
		else $error("ready too long");
	a_err_decode: assert property (setup |=>
		pslverr_o == !($past(paddr_i) inside {8'h0C, 8'h10}))
		else $error("address decode wrong");
	a_err_no_data: assert property (pslverr_o |->
		pready_o && prdata_o == 32'h0)
		else $error("error response wrong");
	a_rdata_hold: assert property (!setup |=> $stable(prdata_o))
		else $error("read data moved");
	a_resp_en_write: assert property (commit && paddr_i == 8'h0C
		&& pstrb_i[0] |-> ##2 resp_enable_o == $past(pwdata_i[0], 2))
		else $error("enable not written");
	a_pace_filt_write: assert property (commit && paddr_i == 8'h10
		&& pstrb_i[1] |-> ##2 pace_width_filter_en_o == $past(pwdata_i[11], 2))
		else $error("width filter not written");
	a_ext_sel_gate: assert property (ext_resp_path_select_o |->
		resp_lead_select_o == 2'h3)
		else $error("path pair without external lead");
	a_pin_follow: assert property (!resp_external_sync_o
		&& !$past(resp_external_sync_o) && !$past(resp_external_sync_o, 2)
		&& $past(rst_n_i) |-> general_pin_three_o ==
		$past(general_pin_three_normal_i))
		else $error("pin three not normal");
	c_commit: cover property (commit);
	c_error: cover property (pslverr_o);
	c_sync_pin: cover property (resp_external_sync_o && general_pin_three_o);
endmodule
bind rpc_regs rpc_regs_monitor u_mon (.core_clk_i, .rst_n_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o,
	.pready_o, .pslverr_o, .resp_enable_o, .ext_resp_path_select_o,
	.resp_lead_select_o, .resp_external_sync_o, .pace_width_filter_en_o,
	.general_pin_three_normal_i, .general_pin_three_o);
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
	error_cnt++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_top;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] s;
		logic [23:0] q; logic e;} rpc_row_t;
	logic core_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic [3:0] pstrb_i;
	logic pslverr_o, er, pv, resp_enable_o, ext_resp_path_select_o;
	logic resp_alternate_freq_o, resp_external_sync_o;
	logic pace_width_filter_en_o, pace_valid_filter_two_en_o;
	logic pace_valid_filter_one_en_o, pace_det_one_enable_o;
	logic pace_det_two_enable_o, pace_det_three_enable_o;
	logic [1:0] resp_lead_select_o, resp_drive_amplitude_o;
	logic [1:0] resp_carrier_freq_o, pace_det_one_lead_o;
	logic [1:0] pace_det_two_lead_o, pace_det_three_lead_o;
	logic general_pin_three_normal_i, general_pin_three_o;
	logic [23:0] sr, sp;
	logic [9:0] resp_v;
	logic [11:0] pace_v;
	int error_cnt = 0;
	int checks_done = 0;
	int n;
	rpc_row_t rows [10] = '{
		'{8'h0C, 32'h000180FF, 4'hF, 24'h0180FF, 1'b0},
		'{8'h0C, 32'h00000000, 4'h1, 24'h018000, 1'b0},
		'{8'h0C, 32'h00FE7FAA, 4'hF, 24'h0000AA, 1'b0},
		'{8'h0C, 32'h00000064, 4'hF, 24'h000064, 1'b0},
		'{8'h0C, 32'h00010051, 4'hF, 24'h010051, 1'b0},
		'{8'h10, 32'h00000FFF, 4'hF, 24'h000FFF, 1'b0},
		'{8'h10, 32'h00000A5D, 4'h2, 24'h000AFF, 1'b0},
		'{8'h10, 32'h00000355, 4'hF, 24'h000355, 1'b0},
		'{8'h03, 32'h000002AA, 4'hF, 24'h000000, 1'b1},
		'{8'h14, 32'h000002AA, 4'hF, 24'h000000, 1'b1}};
	assign resp_v = {resp_alternate_freq_o, resp_external_sync_o,
		ext_resp_path_select_o, resp_lead_select_o, resp_drive_amplitude_o,
		resp_carrier_freq_o, resp_enable_o};
	assign pace_v = {pace_width_filter_en_o, pace_valid_filter_two_en_o,
		pace_valid_filter_one_en_o, pace_det_three_lead_o, pace_det_two_lead_o,
		pace_det_one_lead_o, pace_det_three_enable_o, pace_det_two_enable_o,
		pace_det_one_enable_o};
	rpc_regs uut (.core_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o,
		.resp_enable_o, .ext_resp_path_select_o, .resp_lead_select_o,
		.resp_drive_amplitude_o, .resp_carrier_freq_o, .resp_alternate_freq_o,
		.resp_external_sync_o, .pace_width_filter_en_o,
		.pace_valid_filter_two_en_o, .pace_valid_filter_one_en_o,
		.pace_det_one_lead_o, .pace_det_two_lead_o, .pace_det_three_lead_o,
		.pace_det_one_enable_o, .pace_det_two_enable_o,
		.pace_det_three_enable_o, .general_pin_three_normal_i,
		.general_pin_three_o);
	// ==========================================
	// helpers
	function automatic logic [9:0] resp_exp(input logic [23:0] r);
		return {r[16], r[15], r[7] & (r[6:5] == 2'h3), r[6:0]};
	endfunction
	task automatic stop_test;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic idle(input int c);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		repeat (c) @(posedge core_clk_i);
	endtask
	// leaves the request up so a following call runs back to back
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d, input logic [3:0] s);
		int k;
		k = 0;
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		paddr_i <= a;
		pwrite_i <= w;
		pwdata_i <= d;
		pstrb_i <= s;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge core_clk_i);
			k++;
		end while (pready_o !== 1'b1 && k < 20);
		if (k >= 20)
			error_cnt++;
		rd = prdata_o;
		er = pslverr_o;
	endtask
	task automatic chk_dflt;
		`CHK("resp_rst", 10'h000, resp_v)
		`CHK("pace_rst", 12'hF88, pace_v)
		apb(8'h0C, 1'b0, 32'h0, 4'h0);
		`CHK("resp_rd", 32'h00000000, rd)
		apb(8'h10, 1'b0, 32'h0, 4'h0);
		`CHK("pace_rd", 32'h00000F88, rd)
		sr = 24'h000000;
		sp = 24'h000F88;
	endtask
	// ==========================================
	// stimulus
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	initial begin
		#200000;
		error_cnt++;
		stop_test();
	end
	initial begin
		{rst_n_i, psel_i, penable_i, pwrite_i, general_pin_three_normal_i} = 0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		pstrb_i = 4'h0;
		repeat (5) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		chk_dflt();
		foreach (rows[i]) begin
			apb(rows[i].a, 1'b1, rows[i].d, rows[i].s);
			`CHK("wr_err", rows[i].e, er)
			apb(rows[i].a, 1'b0, 32'h0, 4'h0);
			`CHK("rd_data", {8'h00, rows[i].q}, rd)
			if (!rows[i].e && rows[i].a == 8'h0C)
				sr = rows[i].q;
			else if (!rows[i].e)
				sp = rows[i].q;
			idle(2);
			`CHK("resp_fields", resp_exp(sr), resp_v)
			`CHK("pace_fields", sp[11:0], pace_v)
		end
		general_pin_three_normal_i <= 1'b1;
		idle(3);
		`CHK("pin_normal", 1'b1, general_pin_three_o)
		apb(8'h0C, 1'b1, 32'h00008000, 4'hF);
		idle(3);
		`CHK("pin_sync_idle", 1'b0, general_pin_three_o)
		// 64 kHz periodic carrier: 781 cycles per half period, so the
		// window holds exactly four edges; the 56 kHz carrier gives three
		apb(8'h0C, 1'b1, 32'h00018001, 4'hF);
		idle(3);
		pv = general_pin_three_o;
		n = 0;
		repeat (3124) begin
			@(posedge core_clk_i);
			if (general_pin_three_o !== pv)
				n++;
			pv = general_pin_three_o;
		end
		`CHK("pin_edges", 4, n)
		rst_n_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		chk_dflt();
		idle(1);
		stop_test();
	end
endmodule
`default_nettype wire
